// ===== pwm_line_host.sv
// Host controller for a PWM phase splitter: drives its PWM line and its
// enable / mode select line, takes orders over APB. Assumes an external
// level shifter turns en_level into the line voltage and a pin buffer
// resolves pwm_out / pwm_oe.
//
// Chosen here: register access over APB and the placing of the registers.
`include "pwm_host_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pwm_line_host #(
  parameter int W = 16  // Period and duty width
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  // PWM line pin
  output var  logic                      pwm_out,
  output var  logic                      pwm_oe,
  input  wire logic                      pwm_in,
  // Enable / mode select line
  output var  pwm_host_pkg::en_level_type en_level,
  output var  logic                      stage2_en,
  // Load step comparator pin
  input  wire logic                      load_step
);
  import pwm_host_pkg::*;

  localparam int HOLD_CYC = (`HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ======================================================================
  // Registers and internal signals
  logic [`CTRL_WIDTH-1:0] ctrl_r;        // Control register
  logic [W-1:0]           period_r;      // Per-phase period, cycles
  logic [W-1:0]           duty_r;        // Per-phase on time, cycles
  seq_state_type          state_r;       // Line sequencer
  logic [3:0]             hold_cnt_r;    // Hold-off counter
  logic [2:0]             m2_cnt_r;      // Cycles seen at mode two level
  logic [1:0]             pin_sync_r;    // Line sense synchroniser
  logic [1:0]             step_sync_r;   // Load step synchroniser
  logic                   stage2_r;      // Second stage enable
  logic                   pwm_gen;       // Generator line level
  logic                   cyc_start;     // Generator cycle start
  logic                   wr_en;         // APB write strobe
  logic                   mapped;        // Address decodes
  logic                   boost;         // Forced synchronous
  en_level_type           level_nxt;     // Requested line level
  logic [1:0]             shift;         // Rate factor as shift
  logic [W-1:0]           line_p;        // Line period
  logic [W-1:0]           on_t;          // Clamped on time

  // Map the mode field to a line level
  function automatic en_level_type mode_level(input logic [1:0] m);
    unique case (m)
      2'b00:   mode_level = EN_IL1;
      2'b01:   mode_level = EN_IL2;
      default: mode_level = EN_SYNC;
    endcase
  endfunction

  // ======================================================================
  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign mapped  = (paddr == `OFS_CTRL) || (paddr == `OFS_PERIOD) ||
                   (paddr == `OFS_DUTY) || (paddr == `OFS_STATUS);
  assign pslverr = psel && penable && !mapped;

  // Control register; lock keeps enable set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_en && paddr == `OFS_CTRL) begin
      ctrl_r <= pwdata[`CTRL_WIDTH-1:0];
      if (ctrl_r[`CTRL_LOCK_BIT] && ctrl_r[`CTRL_ENABLE_BIT]) begin
        ctrl_r[`CTRL_ENABLE_BIT] <= 1'b1;
      end
    end
  end

  // Period and duty registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r <= `PERIOD_RESET;
      duty_r   <= `DUTY_RESET;
    end else if (wr_en && paddr == `OFS_PERIOD) begin
      period_r <= pwdata[W-1:0];
    end else if (wr_en && paddr == `OFS_DUTY) begin
      duty_r <= pwdata[W-1:0];
    end
  end

  // Read mux, registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL:   prdata <= {25'h0, ctrl_r};
        `OFS_PERIOD: prdata <= {{(32-W){1'b0}}, period_r};
        `OFS_DUTY:   prdata <= {{(32-W){1'b0}}, duty_r};
        `OFS_STATUS: prdata <= {24'h0, (m2_cnt_r == 3'(`MODE2_PWM_CYCLES)),
                                boost, en_level, pin_sync_r[1], pwm_gen, state_r};
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  // ======================================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r  <= 2'b00;
      step_sync_r <= 2'b00;
    end else begin
      pin_sync_r  <= {pin_sync_r[0], pwm_in};
      step_sync_r <= {step_sync_r[0], load_step};
    end
  end

  // ======================================================================
  // Mode level; a load step may force synchronous while running
  assign boost = ctrl_r[`CTRL_BOOST_BIT] && step_sync_r[1] && (state_r == ST_RUN);

  always_comb begin
    if (state_r == ST_OFF) begin
      level_nxt = EN_OFF;
    end else if (boost) begin
      level_nxt = EN_SYNC;
    end else begin
      level_nxt = mode_level(ctrl_r[`CTRL_MODE_LSB +: 2]);
    end
  end

  // Registered enable / mode level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_level <= EN_OFF;
    end else begin
      en_level <= level_nxt;
    end
  end

  // Second stage enable stays tied high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage2_r <= 1'b1;
    end else begin
      stage2_r <= 1'b1;
    end
  end
  assign stage2_en = stage2_r;

  // ======================================================================
  // Line rate and duty clamp per mode
  always_comb begin
    if (en_level == EN_SYNC) begin
      shift = 2'd0;
    end else if (ctrl_r[`CTRL_CASCADE_BIT]) begin
      shift = 2'd2;
    end else begin
      shift = 2'd1;
    end
    line_p = period_r >> shift;
    on_t   = (duty_r > line_p - W'(1)) ? line_p - W'(1) : duty_r;
  end

  // ======================================================================
  // Line sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_OFF;
      hold_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          hold_cnt_r <= 4'h0;
          if (ctrl_r[`CTRL_ENABLE_BIT]) begin
            state_r <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          hold_cnt_r <= hold_cnt_r + 4'h1;
          if (!ctrl_r[`CTRL_ENABLE_BIT]) begin
            state_r <= ST_OFF;
          end else if (hold_cnt_r == 4'(HOLD_CYC - 1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          hold_cnt_r <= 4'h0;
          if (!ctrl_r[`CTRL_ENABLE_BIT]) begin
            state_r <= ST_OFF;
          end else if (ctrl_r[`CTRL_TRI_BIT]) begin
            state_r <= ST_TRI;
          end
        end
        ST_TRI: begin
          hold_cnt_r <= 4'h0;
          if (!ctrl_r[`CTRL_ENABLE_BIT]) begin
            state_r <= ST_OFF;
          end else if (!ctrl_r[`CTRL_TRI_BIT]) begin
            state_r <= ST_SETTLE;
          end
        end
      endcase
    end
  end

  // Mode two settling: count line cycles at that level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m2_cnt_r <= 3'h0;
    end else if (en_level != EN_IL2) begin
      m2_cnt_r <= 3'h0;
    end else if (cyc_start && m2_cnt_r != 3'(`MODE2_PWM_CYCLES)) begin
      m2_cnt_r <= m2_cnt_r + 3'h1;
    end
  end

  // ======================================================================
  // Pulse generator and pin drive
  pwm_line_gen #(
    .W (W)
  ) u_gen (
    .pclk          (pclk),
    .presetn       (presetn),
    .run           (state_r == ST_RUN),
    .period        (line_p),
    .on_time       (on_t),
    .pwm_r         (pwm_gen),
    .cycle_start_r (cyc_start)
  );

  // Drive low while off, release in settle and tri-state
  assign pwm_out = pwm_gen;
  assign pwm_oe  = (state_r == ST_OFF) || (state_r == ST_RUN);

  // ======================================================================
  // Assertions
  sequence s_settle_entry;
    $rose(state_r == ST_SETTLE);
  endsequence

  // Last hold-off cycle still released, driven again on the next one
  sequence s_line_released;
    !pwm_oe ##1 pwm_oe;
  endsequence

  a_settle_holdoff: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_settle_entry ##0 ctrl_r[`CTRL_ENABLE_BIT] [*7] |-> s_line_released)
    else $error("line not released for exactly the hold-off");
  a_run_after_settle: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(state_r == ST_RUN) |-> $past(state_r) == ST_SETTLE)
    else $error("run entered without settle");
  a_off_ground_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_OFF) [*2] |-> en_level == EN_OFF)
    else $error("enable line not grounded while off");
  a_off_line_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_OFF) [*2] |-> pwm_oe && !pwm_out)
    else $error("line not held low while off");
  a_tri_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_TRI |-> !pwm_oe)
    else $error("line driven in tri-state");
  a_rate_interleave: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_level == EN_IL1 && !ctrl_r[`CTRL_CASCADE_BIT] |-> line_p == period_r / 2)
    else $error("interleave line rate wrong");
  a_cascade_quarter: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_level != EN_SYNC && ctrl_r[`CTRL_CASCADE_BIT] && line_p != '0
      |-> line_p == period_r / 4 && on_t < line_p)
    else $error("cascade rate or duty wrong");
  a_stage2_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    stage2_en)
    else $error("second stage enable dropped");
  a_lock_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_r[`CTRL_LOCK_BIT] && ctrl_r[`CTRL_ENABLE_BIT] |=> ctrl_r[`CTRL_ENABLE_BIT])
    else $error("locked enable was cleared");
  a_boost_sync: assert property (
    @(posedge pclk) disable iff (!presetn)
    boost |=> en_level == EN_SYNC)
    else $error("load step did not force sync");

endmodule // pwm_line_host

`default_nettype wire

// ===== pwm_host_params.svh
// Constants for the PWM line host: register offsets, fields, resets, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
`ifndef PWM_HOST_PARAMS_SVH
`define PWM_HOST_PARAMS_SVH

// ========================================================================
// Register offsets (byte addresses)
`define OFS_CTRL          8'h00
`define OFS_PERIOD        8'h04
`define OFS_DUTY          8'h08
`define OFS_STATUS        8'h0C

// ========================================================================
// Control register fields
`define CTRL_ENABLE_BIT   0
`define CTRL_MODE_LSB     1
`define CTRL_CASCADE_BIT  3
`define CTRL_TRI_BIT      4
`define CTRL_BOOST_BIT    5
`define CTRL_LOCK_BIT     6
`define CTRL_WIDTH        7

// ========================================================================
// Reset values
`define CTRL_RESET        7'h00
`define PERIOD_RESET      16'h0064
`define DUTY_RESET        16'h0014

// ========================================================================
// Timing
`define CLK_PERIOD_NS     10
`define HOLDOFF_NS        65
`define MODE2_PWM_CYCLES  4

`endif

// ===== pwm_host_pkg.sv
// Types shared by the PWM line host modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pwm_host_pkg;

  // ======================================================================
  // Level driven onto the enable / mode select line
  typedef enum logic [1:0] {
    EN_OFF  = 2'b00,  // Ground: splitter disabled
    EN_SYNC = 2'b01,  // Mid level: synchronous
    EN_IL2  = 2'b10,  // Upper level: interleave with fixed extension
    EN_IL1  = 2'b11   // Supply: interleave, variable extension only
  } en_level_type;

  // ======================================================================
  // Line sequencer states
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,  // Disabled, line driven low
    ST_SETTLE = 2'b01,  // Line released, waiting out hold-off
    ST_RUN    = 2'b10,  // Pulses on the line
    ST_TRI    = 2'b11   // Line released for tri-state
  } seq_state_type;

endpackage

// ===== pwm_line_gen.sv
// Pulse generator for one PWM line: period and on time in pclk cycles.
// Assumes on_time below period; a cycle opens with a rising edge unless on_time is zero.
`timescale 1ns/10ps
`default_nettype none

module pwm_line_gen #(
  parameter int W = 16  // Counter width
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] on_time,
  // Line
  output var  logic         pwm_r,
  output var  logic         cycle_start_r
);

  logic [W-1:0] cnt_r;  // Position inside the line cycle

  // ======================================================================
  // Cycle counter, restarts on stop so first pulse begins at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run || cnt_r >= period - W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // ======================================================================
  // Registered line level and cycle start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r         <= 1'b0;
      cycle_start_r <= 1'b0;
    end else begin
      pwm_r         <= run && (cnt_r < on_time);
      cycle_start_r <= run && (cnt_r == '0);
    end
  end

endmodule // pwm_line_gen

`default_nettype wire

// ===== pwm_splitter_model.sv
// Behavioural phase splitter: one PWM line in, two phase outputs.
// Assumes line_drv is high while the host drives the line.
`timescale 1ns/10ps
`default_nettype none

module pwm_splitter_model (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Line and enable from the host
  input  wire logic                       line_drv,
  input  wire logic                       line_val,
  input  wire pwm_host_pkg::en_level_type en_code,
  // Phase outputs and pulse counts
  output var  logic                       pha,
  output var  logic                       phb,
  output var  logic                       ph_tri,
  output var  logic [7:0]                 cnt_a,
  output var  logic [7:0]                 cnt_b
);
  import pwm_host_pkg::*;

  logic       hi_r;    // Line high last cycle
  logic       sel_r;   // Next pulse to phase B
  logic [3:0] tcnt_r;  // Released-line cycles
  wire        hi = line_drv & line_val;

  // ==========================================
  // Phase steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || en_code == EN_OFF) begin  // Off: no doubling
      // Phases parked tri-state; no current sense, so no fault lifts it
      {hi_r, sel_r, pha, phb, ph_tri} <= 5'h01;
      tcnt_r <= 4'h0;
      cnt_a  <= 8'h00;
      cnt_b  <= 8'h00;
    end else begin
      hi_r   <= hi;
      tcnt_r <= line_drv ? 4'h0 : (tcnt_r == 4'h7 ? tcnt_r : tcnt_r + 4'h1);
      if (!line_drv && tcnt_r == 4'h6) begin  // Hold-off run out
        {pha, phb, ph_tri} <= 3'h1;
      end else if (hi && !hi_r) begin  // Rise starts pulse
        ph_tri <= 1'b0;
        if (en_code == EN_SYNC) begin  // Both follow
          {pha, phb} <= 2'h3;
          cnt_a      <= cnt_a + 8'h01;
          cnt_b      <= cnt_b + 8'h01;
        end else begin  // Alternate, A first
          pha   <= !sel_r;
          phb   <= sel_r;
          sel_r <= !sel_r;
          if (sel_r) cnt_b <= cnt_b + 8'h01;
          else cnt_a <= cnt_a + 8'h01;
        end
      end else if (!hi && hi_r) begin  // Fall ends pulse
        {pha, phb} <= 2'h0;
      end
    end
  end
endmodule  // pwm_splitter_model
`default_nettype wire

// ===== test_pwm_line_host.sv
// Self-checking bench for the PWM line host, splitter model on the line.
// Assumes a 100 MHz pclk and the designer's APB register map.
`include "pwm_host_params.svh"
`timescale 1ns/10ps
`default_nettype none

module test_pwm_line_host;
  import pwm_host_pkg::*;

  logic         pclk, presetn, psel, penable, pwrite, load_step, rel_r;
  logic [7:0]   paddr, cnt_a, cnt_b;
  logic [31:0]  pwdata, prdata;
  logic         pready, pslverr, pwm_out, pwm_oe, stage2_en, pha, phb, ph_tri;
  en_level_type en_level;
  int           error_cnt, checks_done;
  wire          pwm_in = pwm_oe ? pwm_out : rel_r;  // Released: no pull-up

  always #5 pclk = ~pclk;
  always @(posedge pclk) rel_r <= presetn ? ~rel_r : 1'b0;  // Floating line pattern

  pwm_line_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_in(pwm_in),
    .en_level(en_level), .stage2_en(stage2_en), .load_step(load_step));
  pwm_splitter_model model (.pclk(pclk), .presetn(presetn), .line_drv(pwm_oe),
    .line_val(pwm_out), .en_code(en_level), .pha(pha), .phb(phb), .ph_tri(ph_tri),
    .cnt_a(cnt_a), .cnt_b(cnt_b));

  // ==========================================
  // Reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo;
    chk(32'h1, 32'h0);  // Wait ran out
    complete_run;
  endtask

  // ==========================================
  // APB master and waits
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (pwm_oe !== v) begin
      @(posedge pclk);
      if (++n > 200) tmo;
    end
  endtask
  task automatic wait_lvl(input en_level_type v);
    int n;
    n = 0;
    while (en_level !== v) begin
      @(posedge pclk);
      if (++n > 50) tmo;
    end
  endtask
  // Cycles high and full period of one line pulse
  task automatic meas(output int hi, output int per);
    int n;
    n = 0; hi = 0; per = 0;
    while (pwm_out !== 1'b0 && n < 500) begin @(posedge pclk); n++; end
    while (pwm_out !== 1'b1 && n < 500) begin @(posedge pclk); n++; end
    while (pwm_out === 1'b1 && n < 500) begin @(posedge pclk); n++; hi++; end
    per = hi;
    while (pwm_out !== 1'b1 && n < 500) begin @(posedge pclk); n++; per++; end
    if (n >= 500) tmo;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    chk(stage2_en, 1'b1);
    chk({pwm_oe, pwm_out, en_level}, {2'h2, EN_OFF});
    apb(1'b0, `OFS_CTRL, 32'h0, q, e); chk(q, 32'h0);
    apb(1'b0, `OFS_PERIOD, 32'h0, q, e); chk(q, 32'h64);
    apb(1'b0, `OFS_DUTY, 32'h0, q, e); chk(q, 32'h14); chk(e, 1'b0);
    apb(1'b0, 8'h10, 32'h0, q, e); chk(q, 32'h0); chk(e, 1'b1);
    wr(`OFS_PERIOD, 32'd20);
    wr(`OFS_DUTY, 32'd6);
  endtask
  task automatic run_mode(input logic [31:0] ctrl, input en_level_type lvl,
                          input int per, input int hi, input logic sync);
    int          n, h, p;
    logic [31:0] q;
    logic        e;
    wr(`OFS_CTRL, ctrl);
    wait_oe(1'b0);
    n = 0;
    while (pwm_oe === 1'b0 && n < 50) begin @(posedge pclk); n++; end
    chk(n, (`HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    chk(en_level, lvl);
    meas(h, p);
    chk(h, hi);
    chk(p, per);
    chk(ph_tri, 1'b0);
    if (sync) chk(cnt_a, cnt_b);
    else chk((cnt_a - cnt_b) <= 8'h01, 1'b1);
    if (lvl == EN_IL2) begin
      repeat (4) meas(h, p);
      apb(1'b0, `OFS_STATUS, 32'h0, q, e);
      chk(q[7], 1'b1);
    end
    wr(`OFS_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({pwm_oe, pwm_out, en_level, ph_tri}, {2'h2, EN_OFF, 1'b1});
  endtask
  task automatic t_tri_boost;
    int          h, p;
    logic [31:0] q;
    logic        e;
    wr(`OFS_CTRL, 32'h01);
    wait_oe(1'b0);
    wait_oe(1'b1);
    wr(`OFS_CTRL, 32'h11);
    wait_oe(1'b0);
    repeat (10) @(posedge pclk);
    chk(ph_tri, 1'b1);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e); chk(q[1:0], 2'h3);
    wr(`OFS_CTRL, 32'h21);
    wait_oe(1'b1);
    meas(h, p);
    chk(ph_tri, 1'b0);
    load_step <= 1'b1;
    wait_lvl(EN_SYNC);
    meas(h, p);
    meas(h, p);
    chk(p, 20);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e);
    chk(q[6], 1'b1);
    load_step <= 1'b0;
    wait_lvl(EN_IL1);
    meas(h, p);
    meas(h, p);
    chk(p, 10);
  endtask
  task automatic t_lock;
    logic [31:0] q;
    logic        e;
    wr(`OFS_CTRL, 32'h41);
    wr(`OFS_CTRL, 32'h0);
    apb(1'b0, `OFS_CTRL, 32'h0, q, e); chk(q[0], 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_CTRL, 32'h0, q, e); chk(q, 32'h0);
    chk({pwm_oe, en_level}, {1'b1, EN_OFF});
  endtask

  // ==========================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; load_step = 0; error_cnt = 0; checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    run_mode(32'h01, EN_IL1, 10, 6, 1'b0);
    run_mode(32'h03, EN_IL2, 10, 6, 1'b0);
    run_mode(32'h05, EN_SYNC, 20, 6, 1'b1);
    run_mode(32'h07, EN_SYNC, 20, 6, 1'b1);
    run_mode(32'h09, EN_IL1, 5, 4, 1'b0);
    t_tri_boost;
    t_lock;
    complete_run;
  end
endmodule  // test_pwm_line_host
`default_nettype wire
